// ### fsgc_params.svh
`ifndef FSGC_PARAMS_SVH
`define FSGC_PARAMS_SVH
// Summary of operation
// - bit 0.0 enables command mode
// - command mode: gate follows bit 2.1
// - no command mode for hand-held scanner
// - each received block inverts receive toggle
// - report valid byte count per block
// - pending flag 0.3 while buffer not empty
// - master toggles ack per byte, confirms
// - station address valid only 0 to 63
// - address from ones and tens selectors
// - bit rate must match network rate
// - selectors sampled once at startup
// - process width 4 to 240 bytes
// - downloaded parameters stored, resent on connect
// - polled and cyclic access supported
// - change-of-state access never enabled
// - identity object class 1 readable
// - unchanged configuration gives defaults
// - get attributes inputs, set attributes outputs
// - command mode blocks master output forwarding
// - command bit sends STX char CR LF
`define FSGC_CMD_EN_BIT     0
`define FSGC_ACK_BIT        0
`define FSGC_GATE_BIT       1
`define FSGC_VER_BIT        2
`define FSGC_PEND_BIT       3
`define FSGC_TOG_BIT        0
`define FSGC_DEV_HANDHELD   4'h3
`define FSGC_ADDR_MAX       7'h3f
`define FSGC_WIDTH_MIN      8'h04
`define FSGC_WIDTH_MAX      8'hf0
`define FSGC_HALF_MAX       8'h78
`define FSGC_WIDTH_DEF      8'h04
`define FSGC_MODE_DEF       1'b0
`define FSGC_IDENT_CLASS    8'h01
`define FSGC_VENDOR_ID      16'h0aaa
`define FSGC_DEVICE_TYPE    16'h0bbb
`define FSGC_PRODUCT_CODE   16'h0ccc
`define FSGC_CH_STX         8'h02
`define FSGC_CH_CR          8'h0d
`define FSGC_CH_LF          8'h0a
`define FSGC_CH_PLUS        8'h2b
`define FSGC_CH_MINUS       8'h2d
`define FSGC_CH_VER         8'h76
`define FSGC_ACC_POLL       2'h1
`define FSGC_ACC_CYCLIC     2'h2
`define FSGC_ACC_COS        2'h3
`endif

// ### fsgc_pkg.sv
package fsgc_pkg;
  typedef enum logic [1:0] {
    FSGC_TX_IDLE = 2'b00,
    FSGC_TX_STX  = 2'b01,
    FSGC_TX_CHR  = 2'b10,
    FSGC_TX_END  = 2'b11
  } fsgc_tx_e;
  typedef enum logic [1:0] {
    FSGC_RD_IDLE = 2'b00,
    FSGC_RD_SEND = 2'b01,
    FSGC_RD_WAIT = 2'b10,
    FSGC_RD_DONE = 2'b11
  } fsgc_rd_e;
endpackage

// ### fsgc_link_if.sv
interface fsgc_link_if;
  logic [7:0]  out_ctl0;
  logic [7:0]  out_ctl1;
  logic [7:0]  out_data2;
  logic [7:0]  out_data;
  logic        out_valid;
  logic [7:0]  in_stat0;
  logic [7:0]  in_stat1;
  logic [7:0]  in_data;
  logic        in_valid;
  logic [7:0]  cfg_width;
  logic        cfg_mode;
  logic [1:0]  cfg_access;
  logic        cfg_write;
  logic [7:0]  ident_attr;
  logic [15:0] ident_value;
  modport gateway (input out_ctl0, out_ctl1, out_data2, out_data, out_valid,
                   cfg_width, cfg_mode, cfg_access, cfg_write, ident_attr,
                   output in_stat0, in_stat1, in_data, in_valid, ident_value);
  modport master (output out_ctl0, out_ctl1, out_data2, out_data, out_valid,
                  cfg_width, cfg_mode, cfg_access, cfg_write, ident_attr,
                  input in_stat0, in_stat1, in_data, in_valid, ident_value);
endinterface

// ### fsgc_gateway.sv
`include "fsgc_params.svh"
module fsgc_gateway (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // fieldbus side
  fsgc_link_if.gateway     bus,
  // rotary selectors and network rate
  input  wire logic [3:0]  address_ones_selector_i,
  input  wire logic [3:0]  address_tens_selector_i,
  input  wire logic [3:0]  bit_rate_selector_i,
  input  wire logic [3:0]  attached_device_selector_i,
  input  wire logic [3:0]  network_rate_i,
  // serial device receive blocks
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_valid_i,
  input  wire logic        rx_block_end_i,
  // serial device transmit
  output logic      [7:0]  tx_data_o,
  output logic             tx_valid_o,
  // status
  output logic      [5:0]  station_address_o,
  output logic             address_valid_o,
  output logic             rate_ok_o,
  output logic             cmd_mode_o,
  output logic             cfg_error_o
);
  localparam int BUF_DEPTH = 1024;

  logic [7:0]       buf_mem [BUF_DEPTH];
  logic [10:0]      wr_cnt_q, wr_cnt_d, rd_ptr_q, rd_ptr_d;
  logic [10:0]      blk_end_q, blk_end_d;
  logic             started_q, started_d;
  logic [3:0]       dev_q, dev_d;
  logic [6:0]       addr_q, addr_d;
  logic [3:0]       rate_q, rate_d;
  logic [7:0]       width_q, width_d;
  logic             mode_q, mode_d;
  logic [1:0]       access_q, access_d;
  logic             cfg_err_q, cfg_err_d;
  logic             ack_prev_q, ack_prev_d;
  logic [7:0]       cmd_prev_q, cmd_prev_d;
  logic             blr_q, blr_d;
  logic [7:0]       dlc_q, dlc_d;
  logic [7:0]       in_data_q, in_data_d;
  logic             in_valid_q, in_valid_d;
  logic [7:0]       tx_q, tx_d;
  logic             txv_q, txv_d;
  logic [7:0]       chr_q, chr_d;
  fsgc_pkg::fsgc_tx_e tx_st_q, tx_st_d;
  logic             cmd_ok;
  logic             ack_edge;
  logic [7:0]       cmd_rise;
  logic [7:0]       half;

  function automatic logic [7:0] fsgc_cmd_char(input logic [7:0] rise, input logic lvl);
    if (rise[`FSGC_GATE_BIT])
      return lvl ? `FSGC_CH_PLUS : `FSGC_CH_MINUS;
    return `FSGC_CH_VER;
  endfunction

  assign cmd_ok   = bus.out_ctl0[`FSGC_CMD_EN_BIT]
                    && (dev_q != `FSGC_DEV_HANDHELD);
  assign ack_edge = bus.out_ctl1[`FSGC_ACK_BIT] ^ ack_prev_q;
  assign cmd_rise = (bus.out_data2 ^ cmd_prev_q)
                    & {5'h00, 1'b1, 1'b1, 1'b0};
  assign half     = {1'b0, bus.cfg_width[7:1]};

  always_comb begin
    started_d  = 1'b1;
    dev_d      = dev_q;
    addr_d     = addr_q;
    rate_d     = rate_q;
    if (!started_q) begin
      dev_d  = attached_device_selector_i;
      addr_d = 7'(address_tens_selector_i) * 7'd10 + 7'(address_ones_selector_i);
      rate_d = bit_rate_selector_i;
    end
    width_d    = width_q;
    mode_d     = mode_q;
    access_d   = access_q;
    cfg_err_d  = cfg_err_q;
    if (bus.cfg_write) begin
      if (bus.cfg_width >= `FSGC_WIDTH_MIN && bus.cfg_width <= `FSGC_WIDTH_MAX
          && half <= `FSGC_HALF_MAX && bus.cfg_access != `FSGC_ACC_COS
          && bus.cfg_access != 2'h0) begin
        width_d   = bus.cfg_width;
        mode_d    = bus.cfg_mode;
        access_d  = bus.cfg_access;
        cfg_err_d = 1'b0;
      end else begin
        cfg_err_d = 1'b1;
      end
    end
  end

  always_comb begin
    wr_cnt_d   = wr_cnt_q;
    blk_end_d  = blk_end_q;
    rd_ptr_d   = rd_ptr_q;
    blr_d      = blr_q;
    dlc_d      = dlc_q;
    in_data_d  = in_data_q;
    in_valid_d = 1'b0;
    ack_prev_d = bus.out_ctl1[`FSGC_ACK_BIT];
    if (rx_valid_i && wr_cnt_q < 11'(BUF_DEPTH))
      wr_cnt_d = wr_cnt_q + 11'h001;
    if (rx_block_end_i) begin
      blk_end_d = rx_valid_i ? wr_cnt_q + 11'h001 : wr_cnt_q;
      dlc_d     = 8'(blk_end_d - rd_ptr_q);
      blr_d     = ~blr_q;
    end
    if (ack_edge && rd_ptr_q < blk_end_q) begin
      in_data_d  = buf_mem[rd_ptr_q[9:0]];
      in_valid_d = 1'b1;
      rd_ptr_d   = rd_ptr_q + 11'h001;
    end else if (ack_edge && !rx_valid_i && rd_ptr_q == wr_cnt_q) begin
      rd_ptr_d  = 11'h000;
      wr_cnt_d  = 11'h000;
      blk_end_d = 11'h000;
    end
  end

  always_comb begin
    tx_st_d    = tx_st_q;
    chr_d      = chr_q;
    tx_d       = tx_q;
    txv_d      = 1'b0;
    cmd_prev_d = cmd_ok ? bus.out_data2 : cmd_prev_q;
    case (tx_st_q)
      fsgc_pkg::FSGC_TX_IDLE: begin
        if (cmd_ok && cmd_rise != 8'h00) begin
          chr_d   = fsgc_cmd_char(cmd_rise, bus.out_data2[`FSGC_GATE_BIT]);
          tx_d    = `FSGC_CH_STX;
          txv_d   = 1'b1;
          tx_st_d = fsgc_pkg::FSGC_TX_STX;
        end else if (!bus.out_ctl0[`FSGC_CMD_EN_BIT] && bus.out_valid) begin
          tx_d  = bus.out_data;
          txv_d = 1'b1;
        end
      end
      fsgc_pkg::FSGC_TX_STX: begin
        tx_d    = chr_q;
        txv_d   = 1'b1;
        tx_st_d = fsgc_pkg::FSGC_TX_CHR;
      end
      fsgc_pkg::FSGC_TX_CHR: begin
        tx_d    = `FSGC_CH_CR;
        txv_d   = 1'b1;
        tx_st_d = fsgc_pkg::FSGC_TX_END;
      end
      fsgc_pkg::FSGC_TX_END: begin
        tx_d    = `FSGC_CH_LF;
        txv_d   = 1'b1;
        tx_st_d = fsgc_pkg::FSGC_TX_IDLE;
      end
      default: tx_st_d = fsgc_pkg::FSGC_TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rx_valid_i && wr_cnt_q < 11'(BUF_DEPTH))
      buf_mem[wr_cnt_q[9:0]] <= rx_data_i;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      started_q  <= 1'b0;
      dev_q      <= 4'h0;
      addr_q     <= 7'h00;
      rate_q     <= 4'h0;
      width_q    <= `FSGC_WIDTH_DEF;
      mode_q     <= `FSGC_MODE_DEF;
      access_q   <= `FSGC_ACC_POLL;
      cfg_err_q  <= 1'b0;
      wr_cnt_q   <= 11'h000;
      blk_end_q  <= 11'h000;
      rd_ptr_q   <= 11'h000;
      blr_q      <= 1'b0;
      dlc_q      <= 8'h00;
      in_data_q  <= 8'h00;
      in_valid_q <= 1'b0;
      ack_prev_q <= 1'b0;
      cmd_prev_q <= 8'h00;
      tx_st_q    <= fsgc_pkg::FSGC_TX_IDLE;
      chr_q      <= 8'h00;
      tx_q       <= 8'h00;
      txv_q      <= 1'b0;
    end else begin
      started_q  <= started_d;
      dev_q      <= dev_d;
      addr_q     <= addr_d;
      rate_q     <= rate_d;
      width_q    <= width_d;
      mode_q     <= mode_d;
      access_q   <= access_d;
      cfg_err_q  <= cfg_err_d;
      wr_cnt_q   <= wr_cnt_d;
      blk_end_q  <= blk_end_d;
      rd_ptr_q   <= rd_ptr_d;
      blr_q      <= blr_d;
      dlc_q      <= dlc_d;
      in_data_q  <= in_data_d;
      in_valid_q <= in_valid_d;
      ack_prev_q <= ack_prev_d;
      cmd_prev_q <= cmd_prev_d;
      tx_st_q    <= tx_st_d;
      chr_q      <= chr_d;
      tx_q       <= tx_d;
      txv_q      <= txv_d;
    end
  end

  always_comb begin
    bus.in_stat0 = 8'h00;
    bus.in_stat0[`FSGC_TOG_BIT]  = blr_q;
    bus.in_stat0[`FSGC_PEND_BIT] = (rd_ptr_q < wr_cnt_q);
    bus.in_stat0[1]              = mode_q;
    bus.in_stat1 = dlc_q;
    case (bus.ident_attr)
      8'h01:   bus.ident_value = `FSGC_VENDOR_ID;
      8'h02:   bus.ident_value = `FSGC_DEVICE_TYPE;
      8'h03:   bus.ident_value = `FSGC_PRODUCT_CODE;
      default: bus.ident_value = 16'h0000;
    endcase
  end
  assign bus.in_data       = in_data_q;
  assign bus.in_valid      = in_valid_q;
  assign tx_data_o         = tx_q;
  assign tx_valid_o        = txv_q;
  assign station_address_o = addr_q[5:0];
  assign address_valid_o   = started_q && (addr_q <= `FSGC_ADDR_MAX);
  assign rate_ok_o         = started_q && (rate_q == network_rate_i);
  assign cmd_mode_o        = cmd_ok;
  assign cfg_error_o       = cfg_err_q;
endmodule // fsgc_gateway

// ### fsgc_master.sv
`include "fsgc_params.svh"
module fsgc_master (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // fieldbus side
  fsgc_link_if.master      bus,
  // user orders
  input  wire logic        cmd_mode_i,
  input  wire logic        gate_i,
  input  wire logic        version_i,
  input  wire logic        read_start_i,
  input  wire logic        connect_i,
  input  wire logic [7:0]  width_i,
  input  wire logic        mode_i,
  input  wire logic [1:0]  access_i,
  input  wire logic [7:0]  out_data_i,
  input  wire logic        out_valid_i,
  // user results
  output logic      [7:0]  rd_data_o,
  output logic             rd_valid_o,
  output logic             rd_done_o
);
  fsgc_pkg::fsgc_rd_e st_q, st_d;
  logic       ack_q, ack_d;
  logic       blr_seen_q, blr_seen_d;
  logic [7:0] rd_q, rd_d;
  logic       rdv_q, rdv_d;
  logic       done_q, done_d;

  always_comb begin
    st_d       = st_q;
    ack_d      = ack_q;
    blr_seen_d = blr_seen_q;
    rd_d       = rd_q;
    rdv_d      = 1'b0;
    done_d     = 1'b0;
    case (st_q)
      fsgc_pkg::FSGC_RD_IDLE: begin
        if (read_start_i && bus.in_stat0[`FSGC_TOG_BIT] != blr_seen_q) begin
          blr_seen_d = bus.in_stat0[`FSGC_TOG_BIT];
          st_d       = fsgc_pkg::FSGC_RD_SEND;
        end
      end
      fsgc_pkg::FSGC_RD_SEND: begin
        ack_d = ~ack_q;
        st_d  = bus.in_stat0[`FSGC_PEND_BIT] ? fsgc_pkg::FSGC_RD_WAIT
                                              : fsgc_pkg::FSGC_RD_DONE;
      end
      fsgc_pkg::FSGC_RD_WAIT: begin
        if (bus.in_valid) begin
          rd_d  = bus.in_data;
          rdv_d = 1'b1;
          st_d  = fsgc_pkg::FSGC_RD_SEND;
        end
      end
      fsgc_pkg::FSGC_RD_DONE: begin
        done_d = 1'b1;
        st_d   = fsgc_pkg::FSGC_RD_IDLE;
      end
      default: st_d = fsgc_pkg::FSGC_RD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_q       <= fsgc_pkg::FSGC_RD_IDLE;
      ack_q      <= 1'b0;
      blr_seen_q <= 1'b0;
      rd_q       <= 8'h00;
      rdv_q      <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      st_q       <= st_d;
      ack_q      <= ack_d;
      blr_seen_q <= blr_seen_d;
      rd_q       <= rd_d;
      rdv_q      <= rdv_d;
      done_q     <= done_d;
    end
  end

  assign bus.out_ctl0   = {7'h00, cmd_mode_i};
  assign bus.out_ctl1   = {7'h00, ack_q};
  assign bus.out_data2  = {5'h00, version_i, gate_i, 1'b0};
  assign bus.out_data   = out_data_i;
  assign bus.out_valid  = out_valid_i;
  assign bus.cfg_width  = width_i;
  assign bus.cfg_mode   = mode_i;
  assign bus.cfg_access = (access_i == `FSGC_ACC_COS) ? `FSGC_ACC_POLL : access_i;
  assign bus.cfg_write  = connect_i;
  assign bus.ident_attr = 8'h00;
  assign rd_data_o      = rd_q;
  assign rd_valid_o     = rdv_q;
  assign rd_done_o      = done_q;
endmodule // fsgc_master

// ### fsgc_assertions.sv
`include "fsgc_params.svh"
module fsgc_assertions (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  // link signals
  input wire logic [7:0]  out_ctl1,
  input wire logic [7:0]  in_stat0,
  input wire logic        in_valid,
  input wire logic [1:0]  cfg_access,
  input wire logic        cfg_write,
  input wire logic [7:0]  ident_attr,
  input wire logic [15:0] ident_value
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  a_valid_after_ack: assert property (
    in_valid |-> $past(out_ctl1[0]) != $past(out_ctl1[0], 2))
    else $error("byte delivered without ack toggle");
  a_valid_one_cycle: assert property (
    in_valid && !$changed(out_ctl1[0]) |=> !in_valid)
    else $error("byte valid longer than one cycle");
  a_toggle_with_pend: assert property (
    $changed(in_stat0[`FSGC_TOG_BIT]) |-> in_stat0[`FSGC_PEND_BIT])
    else $error("block toggle without pending data");
  a_no_byte_empty: assert property (
    $changed(out_ctl1[0]) && !in_stat0[`FSGC_PEND_BIT] |=> !in_valid)
    else $error("byte delivered from empty buffer");
  a_cos_never: assert property (
    cfg_write |-> cfg_access != `FSGC_ACC_COS)
    else $error("change of state access written");
  a_ident_vendor: assert property (
    ident_attr == 8'h01 |-> ident_value == `FSGC_VENDOR_ID)
    else $error("vendor attribute wrong");
  a_ident_type: assert property (
    ident_attr == 8'h02 |-> ident_value == `FSGC_DEVICE_TYPE)
    else $error("device type attribute wrong");
  a_ident_product: assert property (
    ident_attr == 8'h03 |-> ident_value == `FSGC_PRODUCT_CODE)
    else $error("product code attribute wrong");
endmodule // fsgc_assertions

// ### testbench.sv
`include "fsgc_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys_i, rst_i, rx_valid_i, rx_block_end_i, cmd_mode_i, gate_i;
  logic       version_i, read_start_i, connect_i, mode_i, out_valid_i;
  logic [3:0] address_ones_selector_i, address_tens_selector_i;
  logic [3:0] bit_rate_selector_i, attached_device_selector_i, network_rate_i;
  logic [7:0] rx_data_i, out_data_i, width_i, tx_data_o, rd_data_o;
  logic [1:0] access_i;
  logic       tx_valid_o, address_valid_o, rate_ok_o, cmd_mode_o, cfg_error_o;
  logic       rd_valid_o, rd_done_o;
  logic [5:0] station_address_o;
  int         n_fail, cmp_count;
  logic [7:0] txq[$], rdq[$];

  fsgc_link_if lnk();
  fsgc_gateway i_fsgc_gateway (.bus(lnk.gateway), .*);
  fsgc_master i_fsgc_master (.bus(lnk.master), .*);
  fsgc_assertions i_fsgc_assertions (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .out_ctl1(lnk.out_ctl1), .in_stat0(lnk.in_stat0), .in_valid(lnk.in_valid),
    .cfg_access(lnk.cfg_access), .cfg_write(lnk.cfg_write),
    .ident_attr(lnk.ident_attr), .ident_value(lnk.ident_value));

  initial begin
    clk_sys_i = 1'h0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // serial and read byte capture
  always @(posedge clk_sys_i) begin
    if (tx_valid_o === 1'h1) txq.push_back(tx_data_o);
    if (rd_valid_o === 1'h1) rdq.push_back(rd_data_o);
  end

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic boot(logic [3:0] ones, logic [3:0] tens, logic [3:0] dev, logic [3:0] net);
    @(posedge clk_sys_i);
    rst_i <= 1'h1;
    address_ones_selector_i <= ones;
    address_tens_selector_i <= tens;
    attached_device_selector_i <= dev;
    network_rate_i <= net;
    tick(16);
    rst_i <= 1'h0;
    tick(3);
  endtask

  task automatic test_sel;
    boot(4'h5, 4'h3, 4'h0, 4'h2);
    chk("address", 16'h23, station_address_o);
    chk("address ok", 1'h1, address_valid_o);
    chk("rate ok", 1'h1, rate_ok_o);
    chk("default mode", 1'h0, lnk.in_stat0[1]);
    boot(4'h4, 4'h6, `FSGC_DEV_HANDHELD, 4'h1);
    chk("address 64 ok", 1'h0, address_valid_o);
    chk("rate mismatch", 1'h0, rate_ok_o);
    cmd_mode_i <= 1'h1;
    tick(3);
    chk("handheld cmd", 1'h0, cmd_mode_o);
    cmd_mode_i <= 1'h0;
    boot(4'h3, 4'h6, 4'h0, 4'h2);
    address_ones_selector_i <= 4'h1;
    tick(3);
    chk("address 63", 16'h3f, station_address_o);
    chk("address 63 ok", 1'h1, address_valid_o);
    $display("test_sel done");
  endtask

  task automatic test_cmd;
    logic [7:0] ex [12] = '{8'h02, 8'h2b, 8'h0d, 8'h0a, 8'h02, 8'h2d,
                            8'h0d, 8'h0a, 8'h02, 8'h76, 8'h0d, 8'h0a};
    txq.delete();
    cmd_mode_i <= 1'h1;
    tick(3);
    chk("cmd mode", 1'h1, cmd_mode_o);
    gate_i <= 1'h1;
    tick(8);
    gate_i <= 1'h0;
    tick(8);
    version_i <= 1'h1;
    out_data_i <= 8'h41;
    out_valid_i <= 1'h1;
    tick(1);
    out_valid_i <= 1'h0;
    tick(8);
    version_i <= 1'h0;
    chk("cmd tx count", 16'hc, 16'(txq.size()));
    for (int i = 0; i < 12 && i < txq.size(); i++)
      chk("cmd tx byte", ex[i], txq[i]);
    txq.delete();
    cmd_mode_i <= 1'h0;
    tick(3);
    out_valid_i <= 1'h1;
    tick(1);
    out_valid_i <= 1'h0;
    tick(6);
    chk("plain tx count", 16'h1, 16'(txq.size()));
    if (txq.size() > 0) chk("plain tx byte", 8'h41, txq[0]);
    $display("test_cmd done");
  endtask

  task automatic cfg(logic [7:0] w, logic m, logic [1:0] a, logic err);
    width_i <= w;
    mode_i <= m;
    access_i <= a;
    connect_i <= 1'h1;
    tick(1);
    connect_i <= 1'h0;
    tick(4);
    chk("cfg error", err, cfg_error_o);
  endtask

  task automatic test_cfg;
    cfg(8'h04, 1'h0, `FSGC_ACC_POLL, 1'h0);
    cfg(8'hf0, 1'h1, `FSGC_ACC_CYCLIC, 1'h0);
    chk("mode stored", 1'h1, lnk.in_stat0[1]);
    cfg(8'hf1, 1'h0, `FSGC_ACC_POLL, 1'h1);
    chk("mode kept", 1'h1, lnk.in_stat0[1]);
    cfg(8'h03, 1'h0, `FSGC_ACC_POLL, 1'h1);
    $display("test_cfg done");
  endtask

  task automatic test_read;
    logic tog;
    int   k;
    tog = lnk.in_stat0[0];
    rdq.delete();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys_i);
      rx_data_i <= 8'h61 + 8'(i);
      rx_valid_i <= 1'h1;
      rx_block_end_i <= (i == 2);
    end
    @(posedge clk_sys_i);
    rx_valid_i <= 1'h0;
    rx_block_end_i <= 1'h0;
    tick(3);
    chk("block toggle", !tog, lnk.in_stat0[0]);
    chk("byte count", 16'h3, lnk.in_stat1);
    chk("pending set", 1'h1, lnk.in_stat0[3]);
    read_start_i <= 1'h1;
    tick(1);
    read_start_i <= 1'h0;
    k = 0;
    while (rd_done_o !== 1'h1 && k < 300) begin
      @(posedge clk_sys_i);
      k++;
    end
    if (k == 300) begin
      n_fail++;
      $display("[FAIL] rd_done expected 1 seen timeout");
      test_done();
    end
    tick(2);
    chk("read count", 16'h3, 16'(rdq.size()));
    for (int i = 0; i < 3 && i < rdq.size(); i++)
      chk("read byte", 8'h61 + 8'(i), rdq[i]);
    chk("pending clear", 1'h0, lnk.in_stat0[3]);
    $display("test_read done");
  endtask

  initial begin
    rst_i = 1'h1;
    {rx_valid_i, rx_block_end_i, cmd_mode_i, gate_i, version_i, read_start_i} = '0;
    {connect_i, mode_i, out_valid_i, access_i, rx_data_i, out_data_i} = '0;
    {address_ones_selector_i, address_tens_selector_i, attached_device_selector_i} = '0;
    bit_rate_selector_i = 4'h2;
    network_rate_i = 4'h2;
    width_i = 8'h04;
    n_fail = 0;
    cmp_count = 0;
    test_sel();
    test_cmd();
    test_cfg();
    test_read();
    test_done();
  end
endmodule // testbench
